// File: logic/mws_params.svh
/*
 * Timing constants of the mode and wake supervisor.
 * Assumes a 50 MHz core clock. Times are kept in their own unit and
 * converted to clock cycles here or in the top-level module.
 */
`ifndef MWS_PARAMS_SVH
`define MWS_PARAMS_SVH

`define MWS_CLK_NS 20
`define MWS_US_CYC (1000 / `MWS_CLK_NS)

// Mode transition bounds (ms)
`define MWS_POWERUP_TO_STANDBY_MS 70
`define MWS_STANDBY_TO_NORMAL_MS 10
`define MWS_SLEEP_TO_STANDBY_MS 50
`define MWS_RESET_DELAY_MS 8
`define MWS_STARTUP_WD_MS 300

// Wake timing (us, ns)
`define MWS_WAKE_DOM_US 5
`define MWS_WAKE_REC_US 5
`define MWS_LOCAL_WAKE_LATENCY_US 32
`define MWS_REMOTE_WAKE_LATENCY_US 24
`define MWS_LW_FILTER_NS 750
`define MWS_LW_FILTER_CYC ((`MWS_LW_FILTER_NS + `MWS_CLK_NS - 1) / `MWS_CLK_NS)

// Dominant timeouts (us)
`define MWS_DOM_TIMEOUT_US 1000

// Synchroniser reset image: TXD idles recessive (high)
`define MWS_SYNC_RST 7'h04

`endif

// File: logic/mws_pkg.sv
/*
 * Types of the mode and wake supervisor.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package mws_pkg;

    typedef enum logic [2:0] {
        MWS_RESET   = 3'b000,
        MWS_STARTUP = 3'b001,
        MWS_STANDBY = 3'b010,
        MWS_NORMAL  = 3'b011,
        MWS_SLEEP   = 3'b100
    } mws_state_t;

    typedef enum logic [1:0] {
        MWS_RW_DOM = 2'b00,
        MWS_RW_REC = 2'b01,
        MWS_RW_LAT = 2'b10
    } mws_rw_t;

endpackage

`default_nettype wire

// File: logic/mws_supervisor.sv
/*
 * Mode, wake and watchdog supervisor of a power companion with a CAN
 * transceiver: reset delay, start-up and window watchdogs, mode
 * changes, local and remote wake detection, dominant timeouts.
 * Assumes pins and host strobes are asynchronous to MCLK (50 MHz) and
 * that the window period input is static while the watchdog runs.
 */
`default_nettype none
`include "mws_params.svh"

module mws_supervisor
    import mws_pkg::*;
#(
    parameter int RESET_DELAY_CYC = `MWS_RESET_DELAY_MS * 1000 * `MWS_US_CYC,
    parameter int STARTUP_WD_CYC = `MWS_STARTUP_WD_MS * 1000 * `MWS_US_CYC,
    parameter int DOM_TIMEOUT_CYC = `MWS_DOM_TIMEOUT_US * `MWS_US_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Bus and wake pins
    input wire logic WAKE,
    input wire logic BUS_DOM,
    input wire logic TXD,
    // Host strobes and configuration
    input wire logic WD_TRIG,
    input wire logic CMD_NORMAL,
    input wire logic CMD_STANDBY,
    input wire logic CMD_SLEEP,
    input wire logic [18:0] WIN_WD_PERIOD_US,
    // Status to host
    output logic RESET_N,
    output logic [2:0] MODE,
    output logic WD_EXPIRED,
    output logic LOCAL_WAKE,
    output logic REMOTE_WAKE,
    // Transmitter control and failures
    output logic TX_ENABLE,
    output logic TXD_TIMEOUT,
    output logic BUS_CLAMP
);

    localparam int DOM_CYC = `MWS_WAKE_DOM_US * `MWS_US_CYC;
    localparam int REC_CYC = `MWS_WAKE_REC_US * `MWS_US_CYC;
    localparam int RW_LAT_CYC = `MWS_REMOTE_WAKE_LATENCY_US * `MWS_US_CYC;
    localparam int LW_FILT_CYC = `MWS_LW_FILTER_CYC;
    // Latency runs on after the filter so the total from the edge is nominal
    localparam int LW_REST_CYC = `MWS_LOCAL_WAKE_LATENCY_US * `MWS_US_CYC - LW_FILT_CYC;

    function automatic logic [15:0] dom_count(input logic [15:0] c, input logic dom);
        if (!dom) begin
            dom_count = 16'h0000;
        end else if (c == 16'hFFFF) begin
            dom_count = c;
        end else begin
            dom_count = c + 16'h0001;
        end
    endfunction

    // Input synchronisers: three stages, a change counts when stages 2 and 3 agree
    logic [6:0] raw, s1_q, s2_q, s3_q, clean_q, clean_d, rise;
    assign raw = {CMD_SLEEP, CMD_STANDBY, CMD_NORMAL, WD_TRIG, TXD, BUS_DOM, WAKE};

    always_comb begin
        clean_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & clean_q);
        rise = clean_d & ~clean_q;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            s1_q <= `MWS_SYNC_RST;
            s2_q <= `MWS_SYNC_RST;
            s3_q <= `MWS_SYNC_RST;
            clean_q <= `MWS_SYNC_RST;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            clean_q <= clean_d;
        end
    end

    logic wake_lvl, bus_dom, txd_dom, trig, cmd_norm, cmd_stby, cmd_slp;
    assign wake_lvl = clean_q[0];
    assign bus_dom = clean_q[1];
    assign txd_dom = ~clean_q[2];
    assign trig = rise[3];
    assign cmd_norm = rise[4];
    assign cmd_stby = rise[5];
    assign cmd_slp = rise[6];

    mws_state_t st_q, st_d;
    logic lp_active;
    assign lp_active = (st_q == MWS_STANDBY) || (st_q == MWS_SLEEP);

    // Dominant timeouts
    logic [15:0] txd_cnt_q, txd_cnt_d, bus_cnt_q, bus_cnt_d;
    logic txd_to_q, txd_to_d, bus_cl_q, bus_cl_d, tx_en_q, tx_en_d;

    always_comb begin
        txd_cnt_d = dom_count(txd_cnt_q, txd_dom);
        bus_cnt_d = dom_count(bus_cnt_q, bus_dom);
        txd_to_d = txd_dom & (txd_to_q | (txd_cnt_q == 16'(DOM_TIMEOUT_CYC - 1)));
        bus_cl_d = bus_dom & (bus_cl_q | (bus_cnt_q == 16'(DOM_TIMEOUT_CYC - 1)));
        tx_en_d = (st_d == MWS_NORMAL) & ~txd_to_d;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            txd_cnt_q <= 16'h0000;
            bus_cnt_q <= 16'h0000;
            txd_to_q <= 1'b0;
            bus_cl_q <= 1'b0;
            tx_en_q <= 1'b0;
        end else begin
            txd_cnt_q <= txd_cnt_d;
            bus_cnt_q <= bus_cnt_d;
            txd_to_q <= txd_to_d;
            bus_cl_q <= bus_cl_d;
            tx_en_q <= tx_en_d;
        end
    end

    // Local wake: glitch filter, then latency from the accepted edge
    logic lw_lvl_q, lw_lvl_d, lw_busy_q, lw_busy_d, lw_pulse, lw_out_q;
    logic [5:0] lw_fcnt_q, lw_fcnt_d;
    logic [10:0] lw_lcnt_q, lw_lcnt_d;

    always_comb begin
        lw_lvl_d = lw_lvl_q;
        lw_busy_d = lw_busy_q;
        lw_lcnt_d = lw_lcnt_q;
        lw_fcnt_d = 6'h00;
        lw_pulse = 1'b0;
        if (lw_busy_q) begin
            if (lw_lcnt_q == 11'(LW_REST_CYC - 1)) begin
                lw_busy_d = 1'b0;
                lw_pulse = 1'b1;
            end else begin
                lw_lcnt_d = lw_lcnt_q + 11'h001;
            end
        end
        if (wake_lvl != lw_lvl_q) begin
            if (lw_fcnt_q == 6'(LW_FILT_CYC - 1)) begin
                lw_lvl_d = wake_lvl;
                lw_busy_d = 1'b1;
                lw_lcnt_d = 11'h000;
            end else begin
                lw_fcnt_d = lw_fcnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            lw_lvl_q <= 1'b0;
            lw_busy_q <= 1'b0;
            lw_fcnt_q <= 6'h00;
            lw_lcnt_q <= 11'h000;
            lw_out_q <= 1'b0;
        end else begin
            lw_lvl_q <= lw_lvl_d;
            lw_busy_q <= lw_busy_d;
            lw_fcnt_q <= lw_fcnt_d;
            lw_lcnt_q <= lw_lcnt_d;
            lw_out_q <= lw_pulse & lp_active;
        end
    end

    // Remote wake: dominant phase, recessive phase, then report latency
    mws_rw_t rw_q, rw_d;
    logic [10:0] rw_cnt_q, rw_cnt_d;
    logic rw_pulse, rw_out_q;

    always_comb begin
        rw_d = rw_q;
        rw_cnt_d = 11'h000;
        rw_pulse = 1'b0;
        unique case (rw_q)
            MWS_RW_DOM: begin
                if (bus_dom) begin
                    rw_cnt_d = (rw_cnt_q < 11'(DOM_CYC)) ? rw_cnt_q + 11'h001 : rw_cnt_q;
                end else if (rw_cnt_q >= 11'(DOM_CYC)) begin
                    rw_d = MWS_RW_REC;
                    rw_cnt_d = 11'h001;
                end
            end
            MWS_RW_REC: begin
                if (bus_dom) begin
                    rw_d = MWS_RW_DOM;
                    rw_cnt_d = 11'h001;
                end else if (rw_cnt_q == 11'(REC_CYC - 1)) begin
                    rw_d = MWS_RW_LAT;
                end else begin
                    rw_cnt_d = rw_cnt_q + 11'h001;
                end
            end
            MWS_RW_LAT: begin
                if (rw_cnt_q == 11'(RW_LAT_CYC - 1)) begin
                    rw_d = MWS_RW_DOM;
                    rw_pulse = 1'b1;
                end else begin
                    rw_cnt_d = rw_cnt_q + 11'h001;
                end
            end
            default: rw_d = MWS_RW_DOM;
        endcase
        // The low-power receiver only listens in standby and sleep
        if (!lp_active) begin
            rw_d = MWS_RW_DOM;
            rw_cnt_d = 11'h000;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            rw_q <= MWS_RW_DOM;
            rw_cnt_q <= 11'h000;
            rw_out_q <= 1'b0;
        end else begin
            rw_q <= rw_d;
            rw_cnt_q <= rw_cnt_d;
            rw_out_q <= rw_pulse & lp_active;
        end
    end

    // Mode sequencer with reset delay, start-up and window watchdogs
    logic [25:0] st_cnt_q, st_cnt_d, period_cyc;
    logic from_slp_q, from_slp_d, wd_exp_d, wd_exp_q, rst_n_q;
    assign period_cyc = 26'(WIN_WD_PERIOD_US) * 26'(`MWS_US_CYC);

    always_comb begin
        st_d = st_q;
        st_cnt_d = st_cnt_q + 26'h000_0001;
        from_slp_d = from_slp_q;
        wd_exp_d = 1'b0;
        unique case (st_q)
            MWS_RESET: begin
                if (st_cnt_q == 26'(RESET_DELAY_CYC - 1)) begin
                    // Wake from sleep skips the start-up watchdog
                    st_d = from_slp_q ? MWS_STANDBY : MWS_STARTUP;
                    from_slp_d = 1'b0;
                    st_cnt_d = 26'h000_0000;
                end
            end
            MWS_STARTUP: begin
                if (trig) begin
                    st_d = MWS_STANDBY;
                end else if (st_cnt_q == 26'(STARTUP_WD_CYC - 1)) begin
                    st_d = MWS_RESET;
                    wd_exp_d = 1'b1;
                    st_cnt_d = 26'h000_0000;
                end
            end
            MWS_STANDBY: begin
                st_cnt_d = 26'h000_0000;
                if (cmd_norm) begin
                    st_d = MWS_NORMAL;
                end else if (cmd_slp) begin
                    st_d = MWS_SLEEP;
                end
            end
            MWS_NORMAL: begin
                if (trig && st_cnt_q < (period_cyc >> 1)) begin
                    st_d = MWS_RESET;
                    wd_exp_d = 1'b1;
                    st_cnt_d = 26'h000_0000;
                end else if (trig) begin
                    st_cnt_d = 26'h000_0000;
                end else if (st_cnt_q >= period_cyc - 26'h000_0001) begin
                    st_d = MWS_RESET;
                    wd_exp_d = 1'b1;
                    st_cnt_d = 26'h000_0000;
                end else if (cmd_stby) begin
                    st_d = MWS_STANDBY;
                end else if (cmd_slp) begin
                    st_d = MWS_SLEEP;
                end
            end
            MWS_SLEEP: begin
                st_cnt_d = 26'h000_0000;
                if (lw_out_q || rw_out_q) begin
                    st_d = MWS_RESET;
                    from_slp_d = 1'b1;
                end
            end
            default: begin
                st_d = MWS_RESET;
                st_cnt_d = 26'h000_0000;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_q <= MWS_RESET;
            st_cnt_q <= 26'h000_0000;
            from_slp_q <= 1'b0;
            wd_exp_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            st_q <= st_d;
            st_cnt_q <= st_cnt_d;
            from_slp_q <= from_slp_d;
            wd_exp_q <= wd_exp_d;
            rst_n_q <= (st_d != MWS_RESET);
        end
    end

    assign RESET_N = rst_n_q;
    assign MODE = st_q;
    assign WD_EXPIRED = wd_exp_q;
    assign LOCAL_WAKE = lw_out_q;
    assign REMOTE_WAKE = rw_out_q;
    assign TX_ENABLE = tx_en_q;
    assign TXD_TIMEOUT = txd_to_q;
    assign BUS_CLAMP = bus_cl_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_reset_to_startup: assert property (
        st_q == MWS_RESET && st_cnt_q == 26'(RESET_DELAY_CYC - 1) && !from_slp_q
        |=> st_q == MWS_STARTUP && RESET_N) else $error("reset delay did not end in start-up");
    a_wake_to_standby: assert property (
        st_q == MWS_RESET && st_cnt_q == 26'(RESET_DELAY_CYC - 1) && from_slp_q
        |=> st_q == MWS_STANDBY) else $error("sleep wake did not reach standby");
    a_standby_normal: assert property (
        st_q == MWS_STANDBY && cmd_norm |=> st_q == MWS_NORMAL) else $error("normal command ignored");
    a_startup_trigger: assert property (
        st_q == MWS_STARTUP && trig |=> st_q == MWS_STANDBY && RESET_N)
        else $error("start-up trigger did not give standby");
    a_startup_expiry: assert property (
        st_q == MWS_STARTUP && !trig && st_cnt_q == 26'(STARTUP_WD_CYC - 1)
        |=> !RESET_N && WD_EXPIRED ##1 !WD_EXPIRED) else $error("start-up watchdog expiry wrong");
    a_window_closed: assert property (
        st_q == MWS_NORMAL && trig && st_cnt_q < (period_cyc >> 1)
        |=> st_q == MWS_RESET && WD_EXPIRED) else $error("early trigger was accepted");
    a_sleep_holds: assert property (
        st_q == MWS_SLEEP && !LOCAL_WAKE && !REMOTE_WAKE |=> st_q == MWS_SLEEP)
        else $error("sleep left without wake");
    a_rw_dom_len: assert property (
        rw_q == MWS_RW_DOM ##1 rw_q == MWS_RW_REC |-> $past(rw_cnt_q) >= 11'(DOM_CYC))
        else $error("dominant wake phase too short");
    a_rw_rec_len: assert property (
        rw_q == MWS_RW_REC && rw_d == MWS_RW_LAT |-> !bus_dom && rw_cnt_q == 11'(REC_CYC - 1))
        else $error("recessive wake phase too short");
    a_rw_report: assert property (
        rw_q == MWS_RW_LAT && rw_cnt_q == 11'(RW_LAT_CYC - 1) && lp_active
        |=> REMOTE_WAKE ##1 !REMOTE_WAKE) else $error("remote wake not reported");
    a_lw_filter: assert property (
        $changed(lw_lvl_q) |-> $past(lw_fcnt_q) == 6'(LW_FILT_CYC - 1))
        else $error("wake filter too short");
    a_txd_timeout: assert property (
        txd_dom && txd_cnt_q == 16'(DOM_TIMEOUT_CYC - 1) |=> TXD_TIMEOUT && !TX_ENABLE)
        else $error("TXD dominant timeout missed");
    a_txd_hold_off: assert property (
        TXD_TIMEOUT && txd_dom |=> !TX_ENABLE) else $error("transmitter released while dominant");
    a_bus_clamp: assert property (
        bus_dom && bus_cnt_q == 16'(DOM_TIMEOUT_CYC - 1) |=> BUS_CLAMP)
        else $error("bus clamp missed");

    c_reach_normal: cover property (st_q == MWS_STANDBY ##1 st_q == MWS_NORMAL);
    c_window_ok: cover property (st_q == MWS_NORMAL && trig ##1 st_q == MWS_NORMAL);
    c_sleep_wake: cover property (st_q == MWS_SLEEP && REMOTE_WAKE ##1 st_q == MWS_RESET);
    c_txd_timeout: cover property ($rose(TXD_TIMEOUT));

endmodule

`default_nettype wire

// File: bench/mws_host_model.sv
/*
 * Host model that services the start-up and window watchdogs.
 * Assumes a shared MCLK and the supervisor's MODE code; commands come from the bench.
 */
`default_nettype none
module mws_host_model
    import mws_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Supervisor status
    input wire logic [2:0] mode,
    // Bench control
    input wire logic en,
    input wire logic [15:0] trig_at,
    // Trigger strobe
    output logic wd_trig
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q;
    logic [2:0] mode_q;
    // Counts from mode entry or own trigger, the origin the watchdog uses
    always @(posedge mclk) begin
        mode_q <= mode;
        if (rst || mode != mode_q) begin
            cnt_q <= 16'h0000;
            wd_trig <= 1'b0;
        end else if (en && cnt_q == trig_at) begin
            cnt_q <= 16'h0000;
            wd_trig <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            // Five cycles high outlasts the synchroniser, then low to re-arm
            if (cnt_q == 16'h0004) begin
                wd_trig <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: bench/testbench.sv
/*
 * Self-checking bench of the mode and wake supervisor with a host model.
 * Assumes shortened reset, start-up and dominant counts; wake counts are real.
 */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import mws_pkg::*;
    localparam int RD = 20;
    localparam int SW = 200;
    localparam int DT = 60;
    logic MCLK, RST, WAKE, BUS_DOM, TXD, WD_TRIG, CMD_NORMAL, CMD_STANDBY, CMD_SLEEP;
    logic RESET_N, WD_EXPIRED, LOCAL_WAKE, REMOTE_WAKE, TX_ENABLE, TXD_TIMEOUT, BUS_CLAMP;
    logic [18:0] WIN_WD_PERIOD_US;
    logic [2:0] MODE;
    logic host_en;
    logic [15:0] trig_at;
    int mismatches = 0;
    int compares = 0;
    int n;

    mws_supervisor #(.RESET_DELAY_CYC(RD), .STARTUP_WD_CYC(SW), .DOM_TIMEOUT_CYC(DT)) u_dut (
        .MCLK(MCLK), .RST(RST), .WAKE(WAKE), .BUS_DOM(BUS_DOM), .TXD(TXD),
        .WD_TRIG(WD_TRIG), .CMD_NORMAL(CMD_NORMAL), .CMD_STANDBY(CMD_STANDBY),
        .CMD_SLEEP(CMD_SLEEP), .WIN_WD_PERIOD_US(WIN_WD_PERIOD_US), .RESET_N(RESET_N),
        .MODE(MODE), .WD_EXPIRED(WD_EXPIRED), .LOCAL_WAKE(LOCAL_WAKE),
        .REMOTE_WAKE(REMOTE_WAKE), .TX_ENABLE(TX_ENABLE), .TXD_TIMEOUT(TXD_TIMEOUT),
        .BUS_CLAMP(BUS_CLAMP));
    mws_host_model u_host (.mclk(MCLK), .rst(RST), .mode(MODE), .en(host_en),
        .trig_at(trig_at), .wd_trig(WD_TRIG));

    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end

    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Selectors 8 and up compare MODE with (sel - 8)
    function automatic bit hit(input int sel);
        case (sel)
            0: return WD_EXPIRED === 1'b1;
            1: return LOCAL_WAKE === 1'b1;
            2: return REMOTE_WAKE === 1'b1;
            3: return TXD_TIMEOUT === 1'b1;
            4: return BUS_CLAMP === 1'b1;
            5: return TXD_TIMEOUT === 1'b0;
            6: return BUS_CLAMP === 1'b0;
            7: return RESET_N === 1'b1;
            default: return MODE === 3'(sel - 8);
        endcase
    endfunction

    // Samples on the falling edge so registered outputs have settled
    task automatic wait_sig(input int sel, input int lim, input bit must, output int cnt);
        cnt = 0;
        while (!hit(sel) && cnt < lim) begin
            @(negedge MCLK);
            cnt++;
        end
        if (must && cnt >= lim) begin
            mismatches++;
            $display("[FAIL] wait %0d expected event seen none", sel);
            stop_test();
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge MCLK);
    endtask

    task automatic cmd(input int sel);
        @(posedge MCLK);
        case (sel)
            0: CMD_NORMAL <= 1'b1;
            1: CMD_STANDBY <= 1'b1;
            default: CMD_SLEEP <= 1'b1;
        endcase
        cyc(5);
        CMD_NORMAL <= 1'b0;
        CMD_STANDBY <= 1'b0;
        CMD_SLEEP <= 1'b0;
        cyc(4);
    endtask

    task automatic bus_pulse(input int k);
        @(posedge MCLK);
        BUS_DOM <= 1'b1;
        cyc(k);
        BUS_DOM <= 1'b0;
    endtask

    task automatic t_powerup();
        cyc(20);
        @(negedge MCLK);
        chk("reset_n held", RESET_N, 1'b0);
        chk("mode held", MODE, MWS_RESET);
        @(posedge MCLK);
        RST <= 1'b0;
        wait_sig(7, RD + 10, 1, n);
        chk("reset delay", n >= RD && n <= RD + 3, 1'b1);
        chk("startup mode", MODE, MWS_STARTUP);
        wait_sig(0, SW + 10, 1, n);
        chk("startup expiry", n >= SW - 2 && n <= SW + 3, 1'b1);
        chk("expiry resets", MODE, MWS_RESET);
        chk("expiry reset_n", RESET_N, 1'b0);
        $display("test powerup done");
    endtask

    task automatic t_startup_ok();
        @(posedge MCLK);
        trig_at <= 16'h0032;
        host_en <= 1'b1;
        wait_sig(8 + MWS_STANDBY, RD + 100, 1, n);
        chk("standby tx off", TX_ENABLE, 1'b0);
        chk("standby reset_n", RESET_N, 1'b1);
        $display("test startup_ok done");
    endtask

    // Trigger 20 cycles into a 200-cycle period lands in the closed half
    task automatic t_early_trigger();
        @(posedge MCLK);
        trig_at <= 16'h0014;
        cmd(0);
        wait_sig(8 + MWS_NORMAL, 10, 1, n);
        chk("normal tx on", TX_ENABLE, 1'b1);
        wait_sig(0, 60, 1, n);
        chk("early trigger resets", MODE, MWS_RESET);
        wait_sig(8 + MWS_STANDBY, RD + 100, 1, n);
        $display("test early_trigger done");
    endtask

    task automatic t_window();
        @(posedge MCLK);
        trig_at <= 16'h0096;
        cmd(0);
        wait_sig(8 + MWS_NORMAL, 10, 1, n);
        wait_sig(0, 700, 0, n);
        chk("open window kept", n, 700);
        chk("still normal", MODE, MWS_NORMAL);
        $display("test window done");
    endtask

    task automatic t_dom_timeouts();
        @(posedge MCLK);
        TXD <= 1'b0;
        wait_sig(3, DT + 20, 1, n);
        chk("txd timeout time", n >= DT && n <= DT + 6, 1'b1);
        chk("tx off on timeout", TX_ENABLE, 1'b0);
        cyc(20);
        chk("tx held off", TX_ENABLE, 1'b0);
        TXD <= 1'b1;
        wait_sig(5, 10, 1, n);
        @(negedge MCLK);
        chk("tx back on", TX_ENABLE, 1'b1);
        bus_pulse(DT + 20);
        chk("clamp flagged", BUS_CLAMP, 1'b1);
        wait_sig(6, 10, 1, n);
        $display("test dom_timeouts done");
    endtask

    task automatic t_missed_trigger();
        cmd(1);
        wait_sig(8 + MWS_STANDBY, 10, 1, n);
        chk("standby cmd tx off", TX_ENABLE, 1'b0);
        host_en <= 1'b0;
        cmd(0);
        wait_sig(0, 220, 1, n);
        chk("missed window time", n >= 180 && n <= 200, 1'b1);
        chk("missed resets", MODE, MWS_RESET);
        @(posedge MCLK);
        host_en <= 1'b1;
        trig_at <= 16'h0032;
        wait_sig(8 + MWS_STANDBY, RD + 100, 1, n);
        $display("test missed_trigger done");
    endtask

    // Sleep is entered from normal here, well before the host's next trigger
    task automatic t_remote_wake();
        cmd(0);
        chk("normal before sleep", MODE, MWS_NORMAL);
        cmd(2);
        wait_sig(8 + MWS_SLEEP, 10, 1, n);
        bus_pulse(100);
        wait_sig(2, 2000, 0, n);
        chk("short dominant", n, 2000);
        bus_pulse(260);
        cyc(100);
        bus_pulse(100);
        wait_sig(2, 2000, 0, n);
        chk("short recessive", n, 2000);
        chk("sleep kept", MODE, MWS_SLEEP);
        bus_pulse(260);
        wait_sig(2, 1600, 1, n);
        chk("remote latency", n >= 1440 && n <= 1470, 1'b1);
        wait_sig(8 + MWS_STANDBY, RD + 20, 1, n);
        $display("test remote_wake done");
    endtask

    task automatic t_local_wake();
        cmd(2);
        wait_sig(8 + MWS_SLEEP, 10, 1, n);
        cmd(0);
        chk("normal refused in sleep", MODE, MWS_SLEEP);
        WAKE <= ~WAKE;
        cyc(20);
        WAKE <= ~WAKE;
        wait_sig(1, 2000, 0, n);
        chk("wake glitch", n, 2000);
        @(posedge MCLK);
        WAKE <= ~WAKE;
        wait_sig(1, 1700, 1, n);
        chk("local latency", n >= 1580 && n <= 1620, 1'b1);
        wait_sig(8 + MWS_STANDBY, RD + 20, 1, n);
        $display("test local_wake done");
    endtask

    initial begin
        RST = 1'b1;
        WAKE = 1'b0;
        BUS_DOM = 1'b0;
        TXD = 1'b1;
        CMD_NORMAL = 1'b0;
        CMD_STANDBY = 1'b0;
        CMD_SLEEP = 1'b0;
        WIN_WD_PERIOD_US = 19'h0004;
        host_en = 1'b0;
        trig_at = 16'h0000;
        t_powerup();
        t_startup_ok();
        t_early_trigger();
        t_window();
        t_dom_timeouts();
        t_missed_trigger();
        t_remote_wake();
        t_local_wake();
        stop_test();
    end
endmodule
`default_nettype wire
